/* src/oeil_consts.vh */
// Constants for the output enable and interlock logic
`ifndef OEIL_CONSTS_VH
`define OEIL_CONSTS_VH
// APB register offsets
`define OEIL_CTRL_ADDR     12'h000
`define OEIL_PIN1_ADDR     12'h004
`define OEIL_PIN2_ADDR     12'h008
`define OEIL_CMD_ADDR      12'h00C
`define OEIL_STAT_ADDR     12'h010
`define OEIL_TRIG_ADDR     12'h014
// Control register fields
`define OEIL_CTRL_EXTEN_FN  0
`define OEIL_CTRL_EXTEN_POL 1
`define OEIL_CTRL_EXTEN_LAT 2
`define OEIL_CTRL_LOCK_FN   3
`define OEIL_CTRL_LOCK_LAT  4
`define OEIL_CTRL_MEAS_SRC 5
`define OEIL_CTRL_RST      32'h0000_0000
// Programmable pin register fields
`define OEIL_PIN_MODE_LSB  0
`define OEIL_PIN_HIGH_LSB  8
`define OEIL_PIN_PER_LSB   16
`define OEIL_PIN_CNT_LSB   24
`define OEIL_PIN_RST       32'h0000_0001
// Pin modes
`define OEIL_MODE_LOW      2'h0
`define OEIL_MODE_HIGH     2'h1
`define OEIL_MODE_PULSE    2'h2
// Command register bits, write one to act
`define OEIL_CMD_OUT_ON    0
`define OEIL_CMD_OUT_OFF   1
`define OEIL_CMD_PWR_CYC   2
`define OEIL_CMD_AC_CYC    3
`define OEIL_CMD_PROT_CLR  4
`define OEIL_CMD_PIN_START 5
// Trigger out modes
`define OEIL_TMODE_ON      2'h0
`define OEIL_TMODE_MEAS    2'h1
`define OEIL_TMODE_OFF     2'h2
// Timing
`define OEIL_PERIOD_NS     8
`define OEIL_TRIG_MIN_NS   10000
`define OEIL_TOUT_MIN_NS   100000
`define OEIL_PULSE_TICK_NS 10000
`endif

/* src/oeil_top.v */
// Output enable, interlock, programmable pins, triggers and status outputs
//
// Functional notes
// (RULE_01) Enable function off: external enable input never blocks the output.
// (RULE_02) Enable on, normal polarity: high input blocks output, low input allows.
// (RULE_03) Reverse polarity: high input allows output, low input blocks it.
// (RULE_04) Enable latch: blocked until input enabling and a recovery action occurs.
// (RULE_05) Interlock function off: interlock input never blocks the output.
// (RULE_06) Interlock on: high input blocks output, low allows; no polarity option.
// (RULE_07) Interlock latch: blocked until input enabling and a recovery action occurs.
// (RULE_08) Each open-drain pin independently low, high or counted pulse train.
// (RULE_09) Trigger input edge starts measurement when it is the selected source.
// (RULE_10) Trigger output is active high, its event chosen from three modes.
// (RULE_11) Mains good output released during mains fault, pulled low otherwise.
// (RULE_12) Alarm output released on fault or output off, low only otherwise.
// (RULE_13) Far side spaces trigger pulses and holds each for minimum width.
// (RULE_14) Output on needs enable gate, interlock gate and an output-on request.
`timescale 1ns/10ps
`include "oeil_consts.vh"
module oeil_top #(
  parameter TICK_CYC = (`OEIL_PULSE_TICK_NS + `OEIL_PERIOD_NS - 1) / `OEIL_PERIOD_NS,
  parameter TOUT_CYC = (`OEIL_TOUT_MIN_NS + `OEIL_PERIOD_NS - 1) / `OEIL_PERIOD_NS
) (
  // Clock, reset, enable
  input  wire        CORE_CLK,
  input  wire        RST,
  input  wire        CLK_EN,
  // APB slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  output reg  [31:0] PRDATA,
  // Rear connector inputs
  input  wire        EXT_OUTPUT_ENABLE_INPUT,
  input  wire        SAFETY_INTERLOCK_INPUT,
  input  wire        TRIG_IN,
  // System status inputs
  input  wire        MAINS_FAULT,
  input  wire        OTHER_FAULT,
  input  wire        MEAS_DONE,
  // Output gating and measurement start
  output reg         OUTPUT_ON,
  output reg         MEAS_START,
  // Open-drain and open-collector pins, enable high pulls low
  output wire [1:0]  PROG_PIN_O,
  output reg  [1:0]  PROG_PIN_OE,
  output wire        MAINS_INPUT_GOOD_OUTPUT_O,
  output reg         MAINS_INPUT_GOOD_OUTPUT_OE,
  output wire        ALARM_O,
  output reg         ALARM_OE,
  // Trigger output, active high
  output reg         TRIG_OUT
);

  localparam TICK_W = 14;
  localparam TOUT_W = 17;
  localparam N_GATE = 2;

  // Configuration and command state
  reg  [31:0]       ctrl_q;
  reg  [31:0]       pin_cfg_q [0:1];
  reg  [1:0]        tmode_q;
  reg               req_on_q;
  reg  [1:0]        pin_start_q;

  // Trigger and timing state
  reg               trig_in_q;
  reg               meas_busy_q;
  reg               out_on_d1_q;
  reg  [TOUT_W-1:0] tout_cnt_q;
  reg  [TICK_W-1:0] tick_cnt_q;

  // Gate latches, index 0 external enable, index 1 interlock
  wire [N_GATE-1:0] gate_lat;

  // Known register offsets
  function addr_ok;
    input [11:0] a;
    begin
      addr_ok = (a == `OEIL_CTRL_ADDR) || (a == `OEIL_PIN1_ADDR) ||
                (a == `OEIL_PIN2_ADDR) || (a == `OEIL_CMD_ADDR) ||
                (a == `OEIL_STAT_ADDR) || (a == `OEIL_TRIG_ADDR);
    end
  endfunction

  // Write strobe for one register offset
  function reg_wr;
    input        acc;
    input [11:0] a;
    input [11:0] target;
    begin
      reg_wr = acc && (a == target);
    end
  endfunction

  // Register bus decode
  wire wr_acc   = PSEL & PENABLE & PWRITE & CLK_EN;
  wire ctrl_wr  = reg_wr(wr_acc, PADDR, `OEIL_CTRL_ADDR);
  wire pin1_wr  = reg_wr(wr_acc, PADDR, `OEIL_PIN1_ADDR);
  wire pin2_wr  = reg_wr(wr_acc, PADDR, `OEIL_PIN2_ADDR);
  wire tmode_wr = reg_wr(wr_acc, PADDR, `OEIL_TRIG_ADDR);
  wire cmd_wr   = reg_wr(wr_acc, PADDR, `OEIL_CMD_ADDR);

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_ok(PADDR);

  // Command bits
  wire cmd_on    = cmd_wr & PWDATA[`OEIL_CMD_OUT_ON];
  wire cmd_off   = cmd_wr & PWDATA[`OEIL_CMD_OUT_OFF];
  wire cmd_start = cmd_wr & PWDATA[`OEIL_CMD_PIN_START];
  // Recovery actions
  wire recover   = cmd_wr & (PWDATA[`OEIL_CMD_OUT_ON] | PWDATA[`OEIL_CMD_PWR_CYC] |
                             PWDATA[`OEIL_CMD_AC_CYC] | PWDATA[`OEIL_CMD_PROT_CLR]);

  // (RULE_02) Enable level decode
  // (RULE_03) Polarity inversion
  wire exten_block_raw = ctrl_q[`OEIL_CTRL_EXTEN_POL] ? ~EXT_OUTPUT_ENABLE_INPUT
                                                      : EXT_OUTPUT_ENABLE_INPUT;
  // (RULE_01) Function off bypass
  wire exten_block = ctrl_q[`OEIL_CTRL_EXTEN_FN] & exten_block_raw;
  // (RULE_06) Interlock level decode
  // (RULE_05) Function off bypass
  wire lock_block  = ctrl_q[`OEIL_CTRL_LOCK_FN] & SAFETY_INTERLOCK_INPUT;

  // Block and latch option per gate, same index as the latches
  wire [N_GATE-1:0] gate_block  = {lock_block, exten_block};
  wire [N_GATE-1:0] gate_lat_on = {ctrl_q[`OEIL_CTRL_LOCK_LAT],
                                   ctrl_q[`OEIL_CTRL_EXTEN_LAT]};

  // (RULE_14) Combined output gating
  wire out_allow = ~(|gate_block) & ~(|gate_lat);

  // Control register
  always @(posedge CORE_CLK) begin
    if (RST) begin
      ctrl_q <= `OEIL_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= PWDATA;
    end
  end

  // Programmable pin settings
  always @(posedge CORE_CLK) begin
    if (RST) begin
      pin_cfg_q[0] <= `OEIL_PIN_RST;
      pin_cfg_q[1] <= `OEIL_PIN_RST;
    end else if (CLK_EN) begin
      if (pin1_wr)
        pin_cfg_q[0] <= PWDATA;
      if (pin2_wr)
        pin_cfg_q[1] <= PWDATA;
    end
  end

  // Trigger out mode
  always @(posedge CORE_CLK) begin
    if (RST) begin
      tmode_q <= `OEIL_TMODE_ON;
    end else if (tmode_wr) begin
      tmode_q <= PWDATA[1:0];
    end
  end

  // Output request and pulse train start strobes
  always @(posedge CORE_CLK) begin
    if (RST) begin
      req_on_q    <= 1'b0;
      pin_start_q <= 2'h0;
    end else if (CLK_EN) begin
      pin_start_q <= cmd_start ? 2'h3 : 2'h0;
      // Off wins when both bits are written together
      if (cmd_off)
        req_on_q <= 1'b0;
      else if (cmd_on)
        req_on_q <= 1'b1;
    end
  end

  // (RULE_04) Enable latch, index 0
  // (RULE_07) Interlock latch, index 1
  genvar l;
  generate
    for (l = 0; l < N_GATE; l = l + 1) begin : gate
      reg lat_q;
      // Set wins; clear needs the level back and a recovery action, or the latch option off
      always @(posedge CORE_CLK) begin
        if (RST) begin
          lat_q <= 1'b0;
        end else if (CLK_EN) begin
          if (gate_lat_on[l] && gate_block[l])
            lat_q <= 1'b1;
          else if (!gate_lat_on[l] || recover)
            lat_q <= 1'b0;
        end
      end
      assign gate_lat[l] = lat_q;
    end
  endgenerate

  // Output gate
  always @(posedge CORE_CLK) begin
    if (RST) begin
      OUTPUT_ON   <= 1'b0;
      out_on_d1_q <= 1'b0;
    end else if (CLK_EN) begin
      // (RULE_14) Output follows request and gates, held off during mains or other fault
      OUTPUT_ON   <= req_on_q & out_allow & ~MAINS_FAULT & ~OTHER_FAULT;
      out_on_d1_q <= OUTPUT_ON;
    end
  end

  // Trigger input and measurement start
  always @(posedge CORE_CLK) begin
    if (RST) begin
      trig_in_q   <= 1'b0;
      MEAS_START  <= 1'b0;
      meas_busy_q <= 1'b0;
    end else if (CLK_EN) begin
      trig_in_q   <= TRIG_IN;
      // (RULE_09) Rising edge starts measurement
      // (RULE_13) No filtering, far side keeps spacing
      MEAS_START  <= ctrl_q[`OEIL_CTRL_MEAS_SRC] & TRIG_IN & ~trig_in_q;
      if (MEAS_START)
        meas_busy_q <= 1'b1;
      else if (MEAS_DONE)
        meas_busy_q <= 1'b0;
    end
  end

  // (RULE_10) Trigger out mode select
  wire tout_event = (tmode_q == `OEIL_TMODE_ON   && OUTPUT_ON && !out_on_d1_q) ||
                    (tmode_q == `OEIL_TMODE_MEAS && MEAS_DONE && meas_busy_q) ||
                    (tmode_q == `OEIL_TMODE_OFF  && !OUTPUT_ON && out_on_d1_q);

  // Trigger out, stretched to the minimum width
  always @(posedge CORE_CLK) begin
    if (RST) begin
      TRIG_OUT   <= 1'b0;
      tout_cnt_q <= {TOUT_W{1'b0}};
    end else if (CLK_EN) begin
      if (tout_event) begin
        TRIG_OUT   <= 1'b1;
        tout_cnt_q <= TOUT_CYC[TOUT_W-1:0];
      end else if (tout_cnt_q != {TOUT_W{1'b0}}) begin
        tout_cnt_q <= tout_cnt_q - 1'b1;
      end else begin
        TRIG_OUT <= 1'b0;
      end
    end
  end

  // Open-collector status pins
  always @(posedge CORE_CLK) begin
    if (RST) begin
      MAINS_INPUT_GOOD_OUTPUT_OE <= 1'b0;
      ALARM_OE                   <= 1'b0;
    end else if (CLK_EN) begin
      // (RULE_11) Mains good pulled low without fault
      MAINS_INPUT_GOOD_OUTPUT_OE <= ~MAINS_FAULT;
      // (RULE_12) Alarm pulled low only without fault and output on
      ALARM_OE                   <= ~MAINS_FAULT & ~OTHER_FAULT & OUTPUT_ON;
    end
  end

  // Pins only ever pull low
  assign MAINS_INPUT_GOOD_OUTPUT_O = 1'b0;
  assign ALARM_O                   = 1'b0;
  assign PROG_PIN_O                = 2'h0;

  // Shared pulse time base
  wire tick = (tick_cnt_q == {TICK_W{1'b0}});
  always @(posedge CORE_CLK) begin
    if (RST)
      tick_cnt_q <= {TICK_W{1'b0}};
    else if (CLK_EN)
      tick_cnt_q <= tick ? TICK_CYC[TICK_W-1:0] - 1'b1 : tick_cnt_q - 1'b1;
  end

  // (RULE_08) Per-pin low, high or pulse train
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : pin
      reg  [7:0] phase_q;
      reg  [7:0] left_q;
      wire [1:0] mode  = pin_cfg_q[g][`OEIL_PIN_MODE_LSB +: 2];
      wire [7:0] hi_t  = pin_cfg_q[g][`OEIL_PIN_HIGH_LSB +: 8];
      wire [7:0] per_t = pin_cfg_q[g][`OEIL_PIN_PER_LSB +: 8];
      wire [7:0] cnt   = pin_cfg_q[g][`OEIL_PIN_CNT_LSB +: 8];
      always @(posedge CORE_CLK) begin
        if (RST) begin
          phase_q        <= 8'h00;
          left_q         <= 8'h00;
          PROG_PIN_OE[g] <= 1'b1;
        end else if (CLK_EN) begin
          if (pin_start_q[g]) begin
            phase_q <= 8'h00;
            left_q  <= cnt;
          end else if (tick && left_q != 8'h00) begin
            if (phase_q + 8'h01 >= per_t) begin
              phase_q <= 8'h00;
              left_q  <= left_q - 8'h01;
            end else begin
              phase_q <= phase_q + 8'h01;
            end
          end
          case (mode)
            `OEIL_MODE_LOW:   PROG_PIN_OE[g] <= 1'b1;
            `OEIL_MODE_HIGH:  PROG_PIN_OE[g] <= 1'b0;
            `OEIL_MODE_PULSE: PROG_PIN_OE[g] <= ~((left_q != 8'h00) && (phase_q < hi_t));
            default:          PROG_PIN_OE[g] <= 1'b1;
          endcase
        end
      end
    end
  endgenerate

  // APB read mux
  always @* begin
    case (PADDR)
      `OEIL_CTRL_ADDR: PRDATA = ctrl_q;
      `OEIL_PIN1_ADDR: PRDATA = pin_cfg_q[0];
      `OEIL_PIN2_ADDR: PRDATA = pin_cfg_q[1];
      `OEIL_TRIG_ADDR: PRDATA = {30'h0, tmode_q};
      `OEIL_STAT_ADDR: PRDATA = {24'h0, TRIG_OUT, meas_busy_q, gate_lat[1], gate_lat[0],
                                 lock_block, exten_block, req_on_q, OUTPUT_ON};
      default:         PRDATA = 32'h0000_0000;
    endcase
  end

endmodule

/* test/oeil_props.sv */
// Checker of output gating, latches, status pins and triggers
`timescale 1ns/10ps
module oeil_props #(
  parameter TOUT_CYC = 4
) (
  // Clock, reset and register bus
  input wire        CORE_CLK, RST, CLK_EN, PSEL, PENABLE, PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  // Connector and status inputs
  input wire        EXT_OUTPUT_ENABLE_INPUT, SAFETY_INTERLOCK_INPUT, TRIG_IN,
  input wire        MAINS_FAULT, OTHER_FAULT,
  // Observed outputs
  input wire        OUTPUT_ON, MEAS_START, MAINS_INPUT_GOOD_OUTPUT_OE, ALARM_OE, TRIG_OUT
);
  reg  [5:0]  ctl_q;
  reg  [15:0] hi_q;
  wire        wr    = PSEL && PENABLE && PWRITE && CLK_EN;
  wire        e_blk = ctl_q[0] && (EXT_OUTPUT_ENABLE_INPUT ^ ctl_q[1]);
  wire        i_blk = ctl_q[3] && SAFETY_INTERLOCK_INPUT;
  always @(posedge CORE_CLK) begin
    if (RST) ctl_q <= 6'h00;
    else if (wr && PADDR == 12'h000) ctl_q <= PWDATA[5:0];
    hi_q <= TRIG_OUT ? hi_q + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  sequence s_eblk; ctl_q[2] && e_blk && CLK_EN; endsequence
  sequence s_iblk; ctl_q[4] && i_blk && CLK_EN; endsequence
  sequence s_quiet; (CLK_EN && !wr && !e_blk && !i_blk)[*2]; endsequence
  property p_norm; e_blk && !ctl_q[1] && CLK_EN |=> !OUTPUT_ON; endproperty
  a_norm: assert property (p_norm) else $error("output on while enable blocks");
  property p_rev; e_blk && ctl_q[1] && CLK_EN |=> !OUTPUT_ON; endproperty
  a_rev: assert property (p_rev) else $error("output on while reversed enable blocks");
  property p_ilc; i_blk && CLK_EN |=> !OUTPUT_ON; endproperty
  a_ilc: assert property (p_ilc) else $error("output on while interlock blocks");
  property p_elat; s_eblk ##1 s_quiet |-> !OUTPUT_ON; endproperty
  a_elat: assert property (p_elat) else $error("enable latch released alone");
  property p_ilat; s_iblk ##1 s_quiet |-> !OUTPUT_ON; endproperty
  a_ilat: assert property (p_ilat) else $error("interlock latch released alone");
  property p_good; CLK_EN |=> MAINS_INPUT_GOOD_OUTPUT_OE != $past(MAINS_FAULT); endproperty
  a_good: assert property (p_good) else $error("mains good pin wrong");
  property p_alarm;
    ALARM_OE && $past(CLK_EN) |-> !$past(MAINS_FAULT) && !$past(OTHER_FAULT)
      && (OUTPUT_ON || $past(OUTPUT_ON));
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm pulled low wrongly");
  property p_meas; $rose(TRIG_IN) && ctl_q[5] && CLK_EN |=> MEAS_START; endproperty
  a_meas: assert property (p_meas) else $error("trigger edge missed");
  property p_msrc; !ctl_q[5] && CLK_EN |=> !MEAS_START; endproperty
  a_msrc: assert property (p_msrc) else $error("capture without source");
  property p_tout; $fell(TRIG_OUT) |-> hi_q >= TOUT_CYC + 1; endproperty
  a_tout: assert property (p_tout) else $error("trigger out too short");
endmodule
bind oeil_top oeil_props #(.TOUT_CYC(TOUT_CYC)) u_props (
  .CORE_CLK, .RST, .CLK_EN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .EXT_OUTPUT_ENABLE_INPUT, .SAFETY_INTERLOCK_INPUT, .TRIG_IN, .MAINS_FAULT, .OTHER_FAULT,
  .OUTPUT_ON, .MEAS_START, .MAINS_INPUT_GOOD_OUTPUT_OE, .ALARM_OE, .TRIG_OUT);

/* test/oeil_ext.sv */
// External equipment: pull-ups and trigger source
`timescale 1ns/10ps
module oeil_ext #(
  parameter TW   = 3,
  parameter TGAP = 8
) (
  input  wire       clk,
  input  wire [1:0] pin_oe,
  input  wire       good_oe,
  input  wire       alarm_oe,
  output wire [1:0] pin_lvl,
  output wire       good_lvl,
  output wire       alarm_lvl,
  output reg        trig
);
  // Released lines float up to the pull-up
  assign pin_lvl   = ~pin_oe;
  assign good_lvl  = !good_oe;
  assign alarm_lvl = !alarm_oe;
  initial trig = 1'b0;
  task pulse;
    begin
      @(posedge clk) trig <= 1'b1;
      repeat (TW) @(posedge clk);
      trig <= 1'b0;
      repeat (TGAP) @(posedge clk);
    end
  endtask
endmodule

/* test/output_enable_interlock_logic_test.sv */
// Self-checking bench for the output enable and interlock logic
`timescale 1ns/10ps
`include "oeil_consts.vh"
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module output_enable_interlock_logic_test;
  reg         clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, xen = 1, lock = 1;
  reg         mf = 0, of = 0, md = 0, er, ce = 1;
  reg  [11:0] pa = 0;
  reg  [31:0] pwd = 0, rd;
  reg  [8:0]  rows [0:7];
  wire        rdy, err, on, ms, gdoe, aloe, tout, trg, gd, al;
  wire [31:0] prd;
  wire [1:0]  poe, plv;
  integer     n_fail = 0, cmp_count = 0, i, k, p;
  integer     rec [0:3];
  initial forever #4 clk = ~clk;
  oeil_top #(.TICK_CYC(2), .TOUT_CYC(4)) dut_u (
    .CORE_CLK(clk), .RST(rst), .CLK_EN(ce), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PREADY(rdy), .PSLVERR(err), .PRDATA(prd),
    .EXT_OUTPUT_ENABLE_INPUT(xen), .SAFETY_INTERLOCK_INPUT(lock), .TRIG_IN(trg),
    .MAINS_FAULT(mf), .OTHER_FAULT(of), .MEAS_DONE(md), .OUTPUT_ON(on), .MEAS_START(ms),
    .PROG_PIN_O(), .PROG_PIN_OE(poe), .MAINS_INPUT_GOOD_OUTPUT_O(),
    .MAINS_INPUT_GOOD_OUTPUT_OE(gdoe), .ALARM_O(), .ALARM_OE(aloe), .TRIG_OUT(tout));
  oeil_ext u_ext (.clk(clk), .pin_oe(poe), .good_oe(gdoe), .alarm_oe(aloe),
    .pin_lvl(plv), .good_lvl(gd), .alarm_lvl(al), .trig(trg));
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer t;
    begin
      @(posedge clk) {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
      @(posedge clk) pen <= 1'b1;
      t = 0;
      @(posedge clk);
      while (rdy !== 1'b1 && t < 50) begin t++; @(posedge clk); end
      if (t == 50) n_fail++;
      rd = prd;
      er = err;
      {psel, pen} <= 2'b00;
    end
  endtask
  task results;
    begin
      $display("checks %0d failures %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  // Tests need well under 3000 cycles
  initial begin #80000; n_fail++; results; end
  initial begin
    rows = '{9'b000000_111, 9'b000001_110, 9'b000001_011, 9'b000011_111,
             9'b000011_010, 9'b001000_110, 9'b001000_101, 9'b001001_010};
    rec = '{`OEIL_CMD_OUT_ON, `OEIL_CMD_PWR_CYC, `OEIL_CMD_AC_CYC, `OEIL_CMD_PROT_CLR};
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk) `CHK("reset_out", 3'b011, {on, poe})
    apb(0, `OEIL_CTRL_ADDR, 0); `CHK("ctrl", `OEIL_CTRL_RST, rd)
    apb(0, `OEIL_PIN1_ADDR, 0); `CHK("pin1", `OEIL_PIN_RST, rd)
    apb(0, 12'h0FC, 0); `CHK("unmapped", 33'h1_0000_0000, {er, rd})
    for (i = 0; i < 8; i++) begin
      {xen, lock} <= rows[i][2:1];
      apb(1, `OEIL_CTRL_ADDR, {26'h0, rows[i][8:3]});
      apb(1, `OEIL_CMD_ADDR, 32'h1 << `OEIL_CMD_OUT_ON);
      repeat (2) @(posedge clk);
      `CHK("out_on", rows[i][0], on)
    end
    for (i = 0; i < 8; i++) begin
      k = (i < 4) ? 4 : 5;
      apb(1, `OEIL_CTRL_ADDR, (i < 4) ? 32'h05 : 32'h18);
      {xen, lock} <= (i < 4) ? 2'b10 : 2'b01;
      apb(1, `OEIL_CMD_ADDR, 32'h1 << rec[i % 4]);
      {xen, lock} <= 2'b00;
      apb(0, `OEIL_STAT_ADDR, 0); `CHK("latched", 2'b10, {rd[k], on})
      apb(1, `OEIL_CMD_ADDR, 32'h1 << rec[i % 4]);
      apb(0, `OEIL_STAT_ADDR, 0); `CHK("cleared", 1'b0, rd[k])
    end
    apb(1, `OEIL_CMD_ADDR, 32'h1);
    for (i = 0; i < 5; i++) begin
      {mf, of} <= i[1:0];
      if (i == 4) apb(1, `OEIL_CMD_ADDR, 32'h1 << `OEIL_CMD_OUT_OFF);
      repeat (3) @(posedge clk);
      `CHK("good", i[1], gd)
      `CHK("alarm", (i > 0), al)
    end
    apb(1, `OEIL_PIN1_ADDR, {30'h0, `OEIL_MODE_LOW});
    apb(1, `OEIL_PIN2_ADDR, {30'h0, `OEIL_MODE_HIGH});
    repeat (2) @(posedge clk) `CHK("pins", 2'b10, plv)
    apb(1, `OEIL_PIN1_ADDR, 32'h0204_0102);
    apb(1, `OEIL_CMD_ADDR, 32'h1 << `OEIL_CMD_PIN_START);
    k = 0;
    p = 0;
    repeat (60) begin @(posedge clk); k += (plv[0] && !p); p = plv[0]; end
    `CHK("pulses", 4'hA, {k[1:0], plv})
    for (i = 0; i < 2; i++) begin
      apb(1, `OEIL_CTRL_ADDR, i << `OEIL_CTRL_MEAS_SRC);
      k = 0;
      fork u_ext.pulse(); repeat (20) @(posedge clk) k += ms; join
      `CHK("meas", i, k)
    end
    for (i = 0; i < 3; i++) begin
      apb(1, `OEIL_TRIG_ADDR, i);
      repeat (12) @(posedge clk);
      if (i == 1) begin md <= 1; @(posedge clk) md <= 0; end
      else apb(1, `OEIL_CMD_ADDR, i ? 32'h2 : 32'h1);
      k = 0;
      repeat (12) @(posedge clk) k += tout;
      `CHK("trig_out", 1'b1, k inside {[5:11]})
    end
    ce <= 0;
    apb(1, `OEIL_CTRL_ADDR, 32'h3F);
    ce <= 1;
    apb(0, `OEIL_CTRL_ADDR, 0); `CHK("frozen", 32'h20, rd)
    apb(1, `OEIL_CMD_ADDR, 32'h1);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk) `CHK("rerst_out", 3'b011, {on, poe})
    results;
  end
endmodule
